// file: erw_pkg.sv
/*
 * Package for the receive watermark and reduced MII support registers.
 * Assumes a simple synchronous peripheral register port on one clock.
 */
package erw_pkg;

    // ****************************************************************
    // Register byte addresses (word aligned).
    // ****************************************************************
    localparam logic [15:0] ADDR_PM_MASK_HIGH  = 16'h9070;
    localparam logic [15:0] ADDR_PM_CHECKSUM   = 16'h9080;
    localparam logic [15:0] ADDR_PM_START_OFS  = 16'h9090;
    localparam logic [15:0] ADDR_RX_FILTER_CFG = 16'h90a0;
    localparam logic [15:0] ADDR_RX_WATERMARKS = 16'h90b0;
    localparam logic [15:0] ADDR_INT_ENABLES   = 16'h90c0;
    localparam logic [15:0] ADDR_INT_FLAGS     = 16'h90d0;
    localparam logic [15:0] ADDR_MAC_PHY_SUPP  = 16'h9200;

    // Companion address offsets inside each 16-byte group.
    localparam logic [3:0] OFS_BASE = 4'h0;
    localparam logic [3:0] OFS_CLR  = 4'h4;
    localparam logic [3:0] OFS_SET  = 4'h8;
    localparam logic [3:0] OFS_INV  = 4'hc;

    // ****************************************************************
    // Field positions and masks.
    // ****************************************************************
    localparam int EMPTY_LVL_LSB = 0;
    localparam int FULL_LVL_LSB  = 16;
    localparam int FLAG_EMPTY_MARK_EVENT   = 9;
    localparam int FLAG_FULL_MARK_EVENT   = 8;
    localparam int SUPP_RESET    = 11;
    localparam int SUPP_SPEED    = 8;

    localparam logic [31:0] MASK_WATERMARKS = 32'h00ff00ff;
    localparam logic [31:0] MASK_HALF16     = 32'h0000ffff;
    localparam logic [31:0] MASK_INT_ENABLE = 32'h000063ef;
    localparam logic [31:0] MASK_INT_FLAGS  = 32'h000063ef;
    localparam logic [31:0] MASK_FILTER_CFG = 32'h0000dfff;
    localparam logic [31:0] MASK_SUPPORT    = 32'h00000900;
    localparam logic [31:0] RESET_VALUE     = 32'h00000000;

    // Access size codes.
    typedef enum logic [1:0] {
        ERW_SZ_8,
        ERW_SZ_16,
        ERW_SZ_32
    } erw_size_e;

    // Register port request.
    typedef struct packed {
        logic        write;
        logic        read;
        logic [15:0] addr;
        erw_size_e   size;
        logic [31:0] wdata;
    } erw_req_s;

endpackage

// file: erw_regs.sv
/*
 * Receive watermark comparison, flow-control automation and reduced MII
 * support control registers with clear/set/invert companion addresses.
 * Assumes the register port and packet count are synchronous to clk.
 */
`timescale 1ns/1ns
module erw_regs
    import erw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire erw_req_s    req,
    input  wire logic [7:0]  rxPacketCount,
    input  wire logic        autoFlowEnable,
    input  wire logic        rmiiSelected,
    output logic [31:0]      rdata,
    output logic             flowControlOn,
    output logic             fullMarkEvent,
    output logic             emptyMarkEvent,
    output logic             reducedMiiLogicReset,
    output logic             reducedMiiSpeedSel
);

    // ****************************************************************
    // Address decoding.
    // ****************************************************************

    // Group base of an address, dropping the companion offset.
    function automatic logic [15:0] groupOf(input logic [15:0] a);
        groupOf = {a[15:4], 4'h0};
    endfunction

    // Merge a write into a register through its companion operation.
    function automatic logic [31:0] applyOp(input logic [31:0] cur,
                                            input logic [31:0] wd,
                                            input logic [3:0]  op,
                                            input logic [31:0] msk);
        logic [31:0] v;
        v = cur;
        unique case (op)
            OFS_BASE: v = wd;
            OFS_CLR:  v = cur & ~wd;
            OFS_SET:  v = cur | wd;
            OFS_INV:  v = cur ^ wd;
            default:  v = cur;
        endcase
        applyOp = v & msk;
    endfunction

    logic        accessOk;
    logic        wrEn;
    logic [31:0] wdEff;
    logic [31:0] laneMask;
    logic [3:0]  op;
    logic [15:0] grp;

    // Byte accesses are dropped so they can never corrupt a field.
    assign accessOk = (req.size == ERW_SZ_16)
                   || (req.size == ERW_SZ_32);
    assign wrEn     = req.write && accessOk;
    assign op       = req.addr[3:0];
    assign grp      = groupOf(req.addr);
    // A 16-bit access reaches only the lower half of the word.
    assign laneMask = (req.size == ERW_SZ_16) ? MASK_HALF16 : ~32'h0;
    assign wdEff    = req.wdata & laneMask;

    // Keeps the half not covered by a 16-bit plain write intact.
    function automatic logic [31:0] keepHalf(input logic [31:0] cur,
                                             input logic [31:0] nw,
                                             input logic [31:0] lm,
                                             input logic [3:0]  o);
        keepHalf = (o == OFS_BASE) ? ((nw & lm) | (cur & ~lm)) : nw;
    endfunction

    // ****************************************************************
    // Storage registers.
    // ****************************************************************
    logic [31:0] pmMaskHigh_r, pmChecksum_r, pmStartOfs_r, rxFilterCfg_r;
    logic [31:0] rxWatermarks_r, intEnables_r, intFlags_r, macPhySupp_r;

    // Plain storage registers with companion operations.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pmMaskHigh_r  <= RESET_VALUE;
            pmChecksum_r  <= RESET_VALUE;
            pmStartOfs_r  <= RESET_VALUE;
            rxFilterCfg_r <= RESET_VALUE;
            intEnables_r  <= RESET_VALUE;
        end else if (wrEn) begin
            unique case (grp)
                ADDR_PM_MASK_HIGH: pmMaskHigh_r <= keepHalf(pmMaskHigh_r,
                    applyOp(pmMaskHigh_r, wdEff, op, ~32'h0),
                    laneMask, op);
                ADDR_PM_CHECKSUM: pmChecksum_r <= applyOp(pmChecksum_r,
                    wdEff, op, MASK_HALF16);
                ADDR_PM_START_OFS: pmStartOfs_r <= applyOp(pmStartOfs_r,
                    wdEff, op, MASK_HALF16);
                ADDR_RX_FILTER_CFG: rxFilterCfg_r <= applyOp(rxFilterCfg_r,
                    wdEff, op, MASK_FILTER_CFG);
                ADDR_INT_ENABLES: intEnables_r <= applyOp(intEnables_r,
                    wdEff, op, MASK_INT_ENABLE);
                default: ;
            endcase
        end
    end

    // Watermark levels; read by the comparison path and the read data mux below.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxWatermarks_r <= RESET_VALUE;
        end else if (wrEn && grp == ADDR_RX_WATERMARKS) begin
            rxWatermarks_r <= keepHalf(rxWatermarks_r,
                applyOp(rxWatermarks_r, wdEff, op, MASK_WATERMARKS),
                laneMask | ~MASK_WATERMARKS, op);
        end
    end

    // Reduced MII support controls.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            macPhySupp_r <= RESET_VALUE;
        end else if (wrEn && grp == ADDR_MAC_PHY_SUPP) begin
            macPhySupp_r <= applyOp(macPhySupp_r, wdEff, op,
                MASK_SUPPORT);
        end
    end

    // ****************************************************************
    // Watermark comparison and flow control.
    // ****************************************************************
    logic [7:0] fullLevel, emptyLevel;
    logic       fullCond, emptyCond, fullCond_r, emptyCond_r;

    assign fullLevel  = rxWatermarks_r[FULL_LVL_LSB +: 8];
    assign emptyLevel = rxWatermarks_r[EMPTY_LVL_LSB +: 8];
    assign fullCond   = rxPacketCount >= fullLevel;
    assign emptyCond  = rxPacketCount <= emptyLevel;

    // Events fire on entry to a condition so a steady level is one event.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fullCond_r     <= 1'b0;
            emptyCond_r    <= 1'b0;
            fullMarkEvent  <= 1'b0;
            emptyMarkEvent <= 1'b0;
        end else begin
            fullCond_r     <= fullCond;
            emptyCond_r    <= emptyCond;
            fullMarkEvent  <= fullCond && !fullCond_r;
            emptyMarkEvent <= emptyCond && !emptyCond_r;
        end
    end

    // Sticky flags; a hardware set wins over a same-cycle software clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intFlags_r <= RESET_VALUE;
        end else begin
            intFlags_r <= ((wrEn && grp == ADDR_INT_FLAGS)
                ? applyOp(intFlags_r, wdEff, op, MASK_INT_FLAGS) : intFlags_r)
                | ({31'h0, fullCond && !fullCond_r} << FLAG_FULL_MARK_EVENT)
                | ({31'h0, emptyCond && !emptyCond_r} << FLAG_EMPTY_MARK_EVENT);
        end
    end

    // Flow control has hysteresis between the two levels.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flowControlOn <= 1'b0;
        end else if (!autoFlowEnable) begin
            flowControlOn <= 1'b0;
        end else if (fullCond) begin
            flowControlOn <= 1'b1;
        end else if (emptyCond) begin
            flowControlOn <= 1'b0;
        end
    end

    // Reduced MII outputs; inert while standard MII is selected.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reducedMiiLogicReset <= 1'b0;
            reducedMiiSpeedSel   <= 1'b0;
        end else begin
            reducedMiiLogicReset <= rmiiSelected
                && macPhySupp_r[SUPP_RESET];
            reducedMiiSpeedSel   <= rmiiSelected
                && macPhySupp_r[SUPP_SPEED];
        end
    end

    // ****************************************************************
    // Read data.
    // ****************************************************************
    logic [31:0] rdSel;

    // Reads are answered one cycle later; companions read the base.
    always_comb begin
        unique case (grp)
            ADDR_PM_MASK_HIGH:  rdSel = pmMaskHigh_r;
            ADDR_PM_CHECKSUM:   rdSel = pmChecksum_r;
            ADDR_PM_START_OFS:  rdSel = pmStartOfs_r;
            ADDR_RX_FILTER_CFG: rdSel = rxFilterCfg_r;
            ADDR_RX_WATERMARKS: rdSel = rxWatermarks_r;
            ADDR_INT_ENABLES:   rdSel = intEnables_r;
            ADDR_INT_FLAGS:     rdSel = intFlags_r;
            ADDR_MAC_PHY_SUPP:  rdSel = macPhySupp_r;
            default:            rdSel = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= RESET_VALUE;
        end else if (req.read && accessOk) begin
            rdata <= rdSel & laneMask;
        end else begin
            rdata <= RESET_VALUE;
        end
    end

endmodule

// file: erw_regs_properties.sv
/* Checker for the receive watermark and reduced MII support registers.
   Sees only the ports of erw_regs and is bound to it at the foot. */
`timescale 1ns/1ns
module erw_regs_chk
    import erw_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire erw_req_s    req,
    input wire logic        autoFlowEnable,
    input wire logic        rmiiSelected,
    input wire logic [31:0] rdata,
    input wire logic        flowControlOn,
    input wire logic        fullMarkEvent,
    input wire logic        emptyMarkEvent,
    input wire logic        reducedMiiLogicReset,
    input wire logic        reducedMiiSpeedSel
);
    // ***************************************************************
    // Properties on one clock; reset quiets them all.
    // ***************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_full_pulse:
        assert property (fullMarkEvent |=> !fullMarkEvent)
        else $error("Full event lasted more than one cycle.");
    a_empty_pulse:
        assert property (emptyMarkEvent |=> !emptyMarkEvent)
        else $error("Empty event lasted more than one cycle.");
    a_flow_full:
        assert property (fullMarkEvent && $past(autoFlowEnable)
                         |-> flowControlOn)
        else $error("Flow control not on at full event.");
    a_flow_empty:
        assert property (emptyMarkEvent && !fullMarkEvent |-> !flowControlOn)
        else $error("Flow control not off at empty event.");
    a_flow_manual:
        assert property (!autoFlowEnable |=> !flowControlOn)
        else $error("Flow control on without automatic enable.");
    a_mii_inert:
        assert property (!rmiiSelected |=> !reducedMiiLogicReset
                         && !reducedMiiSpeedSel)
        else $error("Reduced MII controls active with standard MII.");
    a_byte_read:
        assert property (!(req.read && req.size != ERW_SZ_8) |=> rdata == '0)
        else $error("Read data without a valid read.");
    a_mark_unused:
        assert property (req.read && req.addr[15:4] == ADDR_RX_WATERMARKS[15:4]
                         |=> (rdata & ~MASK_WATERMARKS) == '0)
        else $error("Unused watermark bits read as one.");
    a_supp_unused:
        assert property (req.read && req.addr[15:4] == ADDR_MAC_PHY_SUPP[15:4]
                         |=> (rdata & ~MASK_SUPPORT) == '0)
        else $error("Unused support bits read as one.");

    // Main scenarios reached.
    c_full_flow: cover property (fullMarkEvent && flowControlOn);
    c_empty: cover property (emptyMarkEvent);
    c_speed: cover property (reducedMiiSpeedSel);
endmodule

bind erw_regs erw_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .req(req),
    .autoFlowEnable(autoFlowEnable), .rmiiSelected(rmiiSelected),
    .rdata(rdata), .flowControlOn(flowControlOn),
    .fullMarkEvent(fullMarkEvent), .emptyMarkEvent(emptyMarkEvent),
    .reducedMiiLogicReset(reducedMiiLogicReset),
    .reducedMiiSpeedSel(reducedMiiSpeedSel));

// file: erw_phy_model.sv
/* Behavioural stand-in for the external PHY on the reduced MII side.
   Assumes the reset and speed controls come straight from erw_regs. */
`timescale 1ns/1ns
module erw_phy_model (
    input  wire logic useRmii,
    input  wire logic logicReset,
    input  wire logic speedSel,
    output logic       rmiiSelected,
    output logic [6:0] rateMbps
);
    // A held reset leaves the link dead, so no rate is reported then.
    assign rmiiSelected = useRmii;
    assign rateMbps = logicReset ? 7'h00
                    : (speedSel ? 7'h64 : 7'h0a);
endmodule

// file: tb.sv
/* Self-checking bench for erw_regs with the PHY model at its far side.
   Assumes a 100 MHz clock and the register port timing of the block. */
`timescale 1ns/1ns
module tb
    import erw_pkg::*;
;
    typedef struct packed {
        logic [15:0] a;
        erw_size_e   s;
        logic [31:0] d;
        logic [31:0] e;
    } erw_row_s;
    // Write, then read the base back; the first row checks the reset value.
    localparam erw_row_s ROWS [15] = '{
        '{16'h90b0, ERW_SZ_8,  32'h000000ff, 32'h00000000},
        '{16'h90b0, ERW_SZ_32, 32'hffffffff, 32'h00ff00ff},
        '{16'h90b4, ERW_SZ_32, 32'h0000000f, 32'h00ff00f0},
        '{16'h90b8, ERW_SZ_16, 32'h00000003, 32'h00ff00f3},
        '{16'h90bc, ERW_SZ_32, 32'h00f00000, 32'h000f00f3},
        '{16'h90b0, ERW_SZ_16, 32'h12340042, 32'h000f0042},
        '{16'h9200, ERW_SZ_32, 32'hffffffff, 32'h00000900},
        '{16'h9204, ERW_SZ_32, 32'h00000100, 32'h00000800},
        '{16'h9300, ERW_SZ_32, 32'hffffffff, 32'h00000000},
        '{16'h9070, ERW_SZ_32, 32'hffffffff, 32'hffffffff},
        '{16'h9070, ERW_SZ_16, 32'h00001234, 32'hffff1234},
        '{16'h9080, ERW_SZ_32, 32'hffffffff, 32'h0000ffff},
        '{16'h9090, ERW_SZ_32, 32'habcd5678, 32'h00005678},
        '{16'h90a0, ERW_SZ_32, 32'hffffffff, 32'h0000dfff},
        '{16'h90c0, ERW_SZ_32, 32'hffffffff, 32'h000063ef}};
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    erw_req_s    req = '0;
    logic [7:0]  count = 8'h00;
    logic        autoFc = 1'b0;
    logic        useRmii = 1'b1;
    logic        rmiiSel, fcOn, fullEv, emptyEv, rmiiRst, rmiiSpd;
    logic [31:0] rdata;
    logic [6:0]  rate;
    int          err_count = 0;
    int          n_compared = 0;

    always #5 clk = ~clk;

    erw_regs dut (.clk(clk), .reset_n(reset_n), .req(req),
        .rxPacketCount(count), .autoFlowEnable(autoFc),
        .rmiiSelected(rmiiSel), .rdata(rdata), .flowControlOn(fcOn),
        .fullMarkEvent(fullEv), .emptyMarkEvent(emptyEv),
        .reducedMiiLogicReset(rmiiRst), .reducedMiiSpeedSel(rmiiSpd));
    erw_phy_model phy (.useRmii(useRmii), .logicReset(rmiiRst),
        .speedSel(rmiiSpd), .rmiiSelected(rmiiSel), .rateMbps(rate));

    // ***************************************************************
    // Shared tasks.
    // ***************************************************************
    task automatic chk(input string nm, input logic [31:0] ex, got);
        n_compared++;
        if (got !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One request held for one cycle; read data stands just after it.
    task automatic acc(input logic w, r, input logic [15:0] a,
                       input erw_size_e s, input logic [31:0] d);
        @(posedge clk);
        #1 req = '{w, r, a, s, d};
        @(posedge clk);
        #1 req = '0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic step(input logic [7:0] c, input logic f, e, fc);
        @(posedge clk);
        #1 count = c;
        @(posedge clk);
        #1 chk("fullEv", 32'(f), 32'(fullEv));
        chk("emptyEv", 32'(e), 32'(emptyEv));
        chk("flowOn", 32'(fc), 32'(fcOn));
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ***************************************************************
    // Main sequence.
    // ***************************************************************
    initial begin
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        foreach (ROWS[i]) begin
            acc(1'b1, 1'b0, ROWS[i].a, ROWS[i].s, ROWS[i].d);
            acc(1'b0, 1'b1, {ROWS[i].a[15:4], 4'h0}, ERW_SZ_32, '0);
            chk("readback", ROWS[i].e, rdata);
        end
        acc(1'b1, 1'b0, 16'h9208, ERW_SZ_32, 32'h00000100);
        settle();
        chk("rateHeld", 32'h0, 32'(rate));
        acc(1'b1, 1'b0, 16'h9204, ERW_SZ_16, 32'h00000800);
        settle();
        chk("rateFast", 32'h64, 32'(rate));
        acc(1'b1, 1'b0, 16'h920c, ERW_SZ_32, 32'h00000100);
        settle();
        chk("rateSlow", 32'h0a, 32'(rate));
        acc(1'b1, 1'b0, 16'h9208, ERW_SZ_32, 32'h00000900);
        #1 useRmii = 1'b0;
        settle();
        chk("miiInert", 32'h0, 32'({rmiiRst, rmiiSpd}));
        useRmii = 1'b1;
        // Watermarks full 5, empty 2; clear stale flags first.
        acc(1'b1, 1'b0, 16'h90b0, ERW_SZ_32, 32'h00050002);
        acc(1'b1, 1'b0, 16'h90d4, ERW_SZ_32, 32'hffffffff);
        autoFc = 1'b1;
        step(8'h03, 1'b0, 1'b0, 1'b0);
        step(8'h05, 1'b1, 1'b0, 1'b1);
        step(8'h06, 1'b0, 1'b0, 1'b1);
        step(8'h02, 1'b0, 1'b1, 1'b0);
        acc(1'b0, 1'b1, 16'h90d0, ERW_SZ_32, '0);
        chk("flags", 32'h00000300, rdata);
        autoFc = 1'b0;
        step(8'h05, 1'b1, 1'b0, 1'b0);
        // An event in the cycle of a clearing write keeps its flag set.
        fork
            acc(1'b1, 1'b0, 16'h90d4, ERW_SZ_32, 32'hffffffff);
            begin
                @(posedge clk);
                #1 count = 8'h01;
            end
        join
        acc(1'b0, 1'b1, 16'h90d0, ERW_SZ_32, '0);
        chk("setWins", 32'h00000200, rdata);
        // Narrow reads: a half word gives the low half, a byte nothing.
        acc(1'b0, 1'b1, 16'h90b0, ERW_SZ_16, '0);
        chk("halfRead", 32'h00000002, rdata);
        acc(1'b0, 1'b1, 16'h90b0, ERW_SZ_8, '0);
        chk("byteRead", 32'h0, rdata);
        // A mid-run reset clears outputs at once and the levels with them.
        reset_n = 1'b0;
        #2;
        chk("resetMii", 32'h0, 32'({rmiiRst, rmiiSpd}));
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        @(posedge clk);
        #1 chk("fullAfterReset", 32'h1, 32'(fullEv));
        acc(1'b0, 1'b1, 16'h90b0, ERW_SZ_32, '0);
        chk("levelsReset", 32'h0, rdata);
        tally_and_finish();
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
endmodule
